// [hdl/pcq_pkg.sv]
// What this block does
// [RULE1] Match fires when oldest entry plus offset equals the selected position.
// [RULE2] Overflow flag rises once stored entries reach the capacity setting.
// [RULE3] A remove command drops the oldest entry; the next one becomes head.
// [RULE4] A remove command also clears the match event.
// [RULE5] Source select picks feedback, master or commanded position.
// [RULE6] With the comparator gate off, the match event never rises.
// [RULE7] While overflow is set, pushes are refused and contents stay unchanged.
// [RULE8] Match target refreshes only on first push into empty store or remove.
// [RULE9] Fill flag is high while count is at or above the fill threshold.
// [RULE10] Entries leave in arrival order; head is the earliest unremoved push.
`default_nettype none
package pcq_pkg;
	localparam int DATA_W  = 32;
	localparam int DEPTH   = 16;
	localparam int CNT_W   = 5;
	localparam int IDX_W   = 4;
	localparam int ADDR_W  = 4;

	// ****************************************************************
	// Register offsets (word addresses)
	// ****************************************************************
	localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
	localparam logic [ADDR_W-1:0] REG_OFFSET   = 4'h1;
	localparam logic [ADDR_W-1:0] REG_CAPACITY = 4'h2;
	localparam logic [ADDR_W-1:0] REG_FILL     = 4'h3;
	localparam logic [ADDR_W-1:0] REG_PUSH     = 4'h4;
	localparam logic [ADDR_W-1:0] REG_CMD      = 4'h5;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h6;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h7;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h8;
	localparam logic [ADDR_W-1:0] REG_HEAD     = 4'h9;
	localparam logic [ADDR_W-1:0] REG_TARGET   = 4'hA;
	localparam logic [ADDR_W-1:0] REG_COUNT    = 4'hB;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_GATE_BIT   = 0;
	localparam int CTRL_SRC_LSB    = 1;
	localparam int CMD_REMOVE_BIT  = 0;
	localparam int CMD_CLEAR_BIT   = 1;
	localparam int ST_MATCH_BIT    = 0;
	localparam int ST_FULLERR_BIT  = 1;
	localparam int ST_FILL_BIT     = 2;
	localparam int ST_EMPTY_BIT    = 3;
	localparam int IRQ_W           = 3;
	localparam int IRQ_MATCH_BIT   = 0;
	localparam int IRQ_FULLERR_BIT = 1;
	localparam int IRQ_FILL_BIT    = 2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [CNT_W-1:0]  CAPACITY_RST = 5'h10;
	localparam logic [CNT_W-1:0]  FILL_RST     = 5'h10;
	localparam logic [DATA_W-1:0] OFFSET_RST   = 32'h0000_0000;

	typedef enum logic [1:0] {
		PCQ_SRC_FEEDBACK,
		PCQ_SRC_MASTER,
		PCQ_SRC_COMMAND
	} pcq_src_e;
endpackage
`default_nettype wire

// [hdl/pcq_store.sv]
`timescale 1ns/10ps
`default_nettype none
module pcq_store (
	input  wire logic                            i_mclk,
	input  wire logic                            i_reset_n,
	input  wire logic                            i_push,
	input  wire logic                            i_pop,
	input  wire logic                            i_clear,
	input  wire logic [pcq_pkg::DATA_W-1:0]      i_data,
	input  wire logic [pcq_pkg::CNT_W-1:0]       i_capacity,
	output logic      [pcq_pkg::DATA_W-1:0]      o_head,
	output logic      [pcq_pkg::DATA_W-1:0]      o_second,
	output logic      [pcq_pkg::CNT_W-1:0]       o_count,
	output logic                                 o_full,
	output logic                                 o_push_taken
);
	logic [pcq_pkg::DATA_W-1:0] mem_r [pcq_pkg::DEPTH];
	logic [pcq_pkg::DATA_W-1:0] mem_nxt [pcq_pkg::DEPTH];
	logic [pcq_pkg::IDX_W-1:0]  rd_r;
	logic [pcq_pkg::IDX_W-1:0]  rd_nxt;
	logic [pcq_pkg::IDX_W-1:0]  wr_r;
	logic [pcq_pkg::IDX_W-1:0]  wr_nxt;
	logic [pcq_pkg::CNT_W-1:0]  cnt_r;
	logic [pcq_pkg::CNT_W-1:0]  cnt_nxt;
	logic [pcq_pkg::CNT_W-1:0]  cap;
	logic                       do_pop;

	// A capacity of zero or above the storage depth is clamped to the depth.
	assign cap = (i_capacity == '0 || i_capacity > pcq_pkg::CNT_W'(pcq_pkg::DEPTH)) ?
		pcq_pkg::CNT_W'(pcq_pkg::DEPTH) : i_capacity;
	assign o_full = (cnt_r >= cap); // RULE2
	assign o_push_taken = i_push && !o_full && !i_clear; // RULE7
	assign do_pop = i_pop && (cnt_r != '0) && !i_clear;
	assign o_head = mem_r[rd_r]; // RULE10
	assign o_second = mem_r[rd_r + 1'b1];
	assign o_count = cnt_r;

	function automatic logic [pcq_pkg::CNT_W-1:0] cnt_one(input logic b);
		cnt_one = {{(pcq_pkg::CNT_W-1){1'b0}}, b};
	endfunction

	always_comb begin
		mem_nxt = mem_r;
		rd_nxt  = rd_r;
		wr_nxt  = wr_r;
		cnt_nxt = cnt_r;
		if (i_clear) begin
			rd_nxt  = '0;
			wr_nxt  = '0;
			cnt_nxt = '0;
		end else begin
			if (o_push_taken) begin
				mem_nxt[wr_r] = i_data; // RULE10
				wr_nxt = wr_r + 1'b1;
			end
			if (do_pop) begin
				rd_nxt = rd_r + 1'b1; // RULE3
			end
			cnt_nxt = cnt_r + cnt_one(o_push_taken) - cnt_one(do_pop);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			rd_r  <= '0;
			wr_r  <= '0;
			cnt_r <= '0;
		end else begin
			rd_r  <= rd_nxt;
			wr_r  <= wr_nxt;
			cnt_r <= cnt_nxt;
		end
		mem_r <= mem_nxt;
	end
endmodule
`default_nettype wire

// [hdl/pcq_top.sv]
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module pcq_top (
	input  wire logic                            i_mclk,
	input  wire logic                            i_reset_n,
	input  wire logic [pcq_pkg::ADDR_W-1:0]      i_addr,
	input  wire logic [pcq_pkg::DATA_W-1:0]      i_wdata,
	input  wire logic                            i_wr,
	input  wire logic                            i_rd,
	output logic      [pcq_pkg::DATA_W-1:0]      o_rdata,
	input  wire logic [pcq_pkg::DATA_W-1:0]      i_feedback_pos,
	input  wire logic [pcq_pkg::DATA_W-1:0]      i_master_pos,
	input  wire logic [pcq_pkg::DATA_W-1:0]      i_command_pos,
	output logic                                 o_match_event,
	output logic                                 o_store_full_error,
	output logic                                 o_fill_flag,
	output logic                                 o_irq
);
	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic                         gate_r, gate_nxt;
	logic [1:0]                   src_r, src_nxt;
	logic [pcq_pkg::DATA_W-1:0]   offset_r, offset_nxt;
	logic [pcq_pkg::CNT_W-1:0]    cap_r, cap_nxt;
	logic [pcq_pkg::CNT_W-1:0]    fill_r, fill_nxt;
	logic [pcq_pkg::IRQ_W-1:0]    mask_r, mask_nxt;
	logic [pcq_pkg::IRQ_W-1:0]    ist_r, ist_nxt;
	logic [pcq_pkg::DATA_W-1:0]   rdata_r, rdata_nxt;

	// ****************************************************************
	// Event state
	// ****************************************************************
	logic [pcq_pkg::DATA_W-1:0]   target_r, target_nxt;
	logic                         target_ok_r, target_ok_nxt;
	logic                         match_r, match_nxt;
	logic                         full_r, full_nxt;
	logic                         fill_flag_r, fill_flag_nxt;
	logic                         irq_r, irq_nxt;

	logic                         wr_push, wr_remove, wr_clear;
	logic [pcq_pkg::DATA_W-1:0]   head, second;
	logic [pcq_pkg::CNT_W-1:0]    count;
	logic                         store_full, push_taken;
	logic [pcq_pkg::DATA_W-1:0]   position;

	function automatic logic hit(input logic [pcq_pkg::ADDR_W-1:0] a,
			input logic [pcq_pkg::ADDR_W-1:0] r);
		hit = (a == r);
	endfunction

	// The overflow flag lags the store by a cycle; a push is refused while it shows.
	assign wr_push   = i_wr && hit(i_addr, pcq_pkg::REG_PUSH) && !full_r; // RULE7
	assign wr_remove = i_wr && hit(i_addr, pcq_pkg::REG_CMD) && i_wdata[pcq_pkg::CMD_REMOVE_BIT];
	assign wr_clear  = i_wr && hit(i_addr, pcq_pkg::REG_CMD) && i_wdata[pcq_pkg::CMD_CLEAR_BIT];

	pcq_store u_store (
		.i_mclk       (i_mclk),
		.i_reset_n    (i_reset_n),
		.i_push       (wr_push),
		.i_pop        (wr_remove),
		.i_clear      (wr_clear),
		.i_data       (i_wdata),
		.i_capacity   (cap_r),
		.o_head       (head),
		.o_second     (second),
		.o_count      (count),
		.o_full       (store_full),
		.o_push_taken (push_taken)
	);

	// Source selection; an unused code falls back to feedback position.
	always_comb begin
		case (pcq_pkg::pcq_src_e'(src_r))
			pcq_pkg::PCQ_SRC_MASTER:  position = i_master_pos; // RULE5
			pcq_pkg::PCQ_SRC_COMMAND: position = i_command_pos; // RULE5
			default:                  position = i_feedback_pos; // RULE5
		endcase
	end

	// ****************************************************************
	// Comparator and flags
	// ****************************************************************
	always_comb begin
		target_nxt    = target_r;
		target_ok_nxt = target_ok_r;
		match_nxt     = match_r;
		if (wr_clear) begin
			target_ok_nxt = 1'b0;
			match_nxt     = 1'b0;
		end else if (wr_remove && count != '0) begin
			match_nxt = 1'b0; // RULE4
			if (count > pcq_pkg::CNT_W'(1)) begin
				target_nxt = second + offset_r; // RULE8
			end else begin
				target_ok_nxt = 1'b0;
			end
		end else begin
			if (push_taken && count == '0) begin
				target_nxt    = i_wdata + offset_r; // RULE8
				target_ok_nxt = 1'b1;
			end
			if (gate_r && target_ok_r && target_r == position) begin // RULE6
				match_nxt = 1'b1; // RULE1
			end
		end
		if (wr_remove && count == '0) begin
			match_nxt = 1'b0; // RULE4
		end
		full_nxt      = store_full; // RULE2
		fill_flag_nxt = (count >= fill_r); // RULE9
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			target_r    <= '0;
			target_ok_r <= 1'b0;
			match_r     <= 1'b0;
			full_r      <= 1'b0;
			fill_flag_r <= 1'b0;
		end else begin
			target_r    <= target_nxt;
			target_ok_r <= target_ok_nxt;
			match_r     <= match_nxt;
			full_r      <= full_nxt;
			fill_flag_r <= fill_flag_nxt;
		end
	end

	// ****************************************************************
	// Register file and interrupt
	// ****************************************************************
	always_comb begin
		gate_nxt   = gate_r;
		src_nxt    = src_r;
		offset_nxt = offset_r;
		cap_nxt    = cap_r;
		fill_nxt   = fill_r;
		mask_nxt   = mask_r;
		ist_nxt    = ist_r;
		rdata_nxt  = '0;
		if (i_wr) begin
			case (i_addr)
				pcq_pkg::REG_CTRL: begin
					gate_nxt = i_wdata[pcq_pkg::CTRL_GATE_BIT];
					src_nxt  = i_wdata[pcq_pkg::CTRL_SRC_LSB +: 2];
				end
				pcq_pkg::REG_OFFSET:   offset_nxt = i_wdata;
				pcq_pkg::REG_CAPACITY: cap_nxt = i_wdata[pcq_pkg::CNT_W-1:0];
				pcq_pkg::REG_FILL:     fill_nxt = i_wdata[pcq_pkg::CNT_W-1:0];
				pcq_pkg::REG_IRQ_MASK: mask_nxt = i_wdata[pcq_pkg::IRQ_W-1:0];
				pcq_pkg::REG_IRQ_STAT: ist_nxt = ist_r & ~i_wdata[pcq_pkg::IRQ_W-1:0];
				default: begin
				end
			endcase
		end
		// Rising edges set sticky bits after the clear so that a set wins.
		if (match_nxt && !match_r) begin
			ist_nxt[pcq_pkg::IRQ_MATCH_BIT] = 1'b1;
		end
		if (full_nxt && !full_r) begin
			ist_nxt[pcq_pkg::IRQ_FULLERR_BIT] = 1'b1;
		end
		if (fill_flag_nxt && !fill_flag_r) begin
			ist_nxt[pcq_pkg::IRQ_FILL_BIT] = 1'b1;
		end
		irq_nxt = |(ist_nxt & mask_nxt);
		if (i_rd) begin
			case (i_addr)
				pcq_pkg::REG_CTRL: begin
					rdata_nxt[pcq_pkg::CTRL_GATE_BIT]      = gate_r;
					rdata_nxt[pcq_pkg::CTRL_SRC_LSB +: 2]  = src_r;
				end
				pcq_pkg::REG_OFFSET:   rdata_nxt = offset_r;
				pcq_pkg::REG_CAPACITY: rdata_nxt[pcq_pkg::CNT_W-1:0] = cap_r;
				pcq_pkg::REG_FILL:     rdata_nxt[pcq_pkg::CNT_W-1:0] = fill_r;
				pcq_pkg::REG_STATUS: begin
					rdata_nxt[pcq_pkg::ST_MATCH_BIT]   = match_r;
					rdata_nxt[pcq_pkg::ST_FULLERR_BIT] = full_r;
					rdata_nxt[pcq_pkg::ST_FILL_BIT]    = fill_flag_r;
					rdata_nxt[pcq_pkg::ST_EMPTY_BIT]   = (count == '0);
				end
				pcq_pkg::REG_IRQ_STAT: rdata_nxt[pcq_pkg::IRQ_W-1:0] = ist_r;
				pcq_pkg::REG_IRQ_MASK: rdata_nxt[pcq_pkg::IRQ_W-1:0] = mask_r;
				pcq_pkg::REG_HEAD:     rdata_nxt = head;
				pcq_pkg::REG_TARGET:   rdata_nxt = target_r;
				pcq_pkg::REG_COUNT:    rdata_nxt[pcq_pkg::CNT_W-1:0] = count;
				default:               rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			gate_r   <= 1'b0;
			src_r    <= 2'h0;
			offset_r <= pcq_pkg::OFFSET_RST;
			cap_r    <= pcq_pkg::CAPACITY_RST;
			fill_r   <= pcq_pkg::FILL_RST;
			mask_r   <= '0;
			ist_r    <= '0;
			rdata_r  <= '0;
			irq_r    <= 1'b0;
		end else begin
			gate_r   <= gate_nxt;
			src_r    <= src_nxt;
			offset_r <= offset_nxt;
			cap_r    <= cap_nxt;
			fill_r   <= fill_nxt;
			mask_r   <= mask_nxt;
			ist_r    <= ist_nxt;
			rdata_r  <= rdata_nxt;
			irq_r    <= irq_nxt;
		end
	end

	assign o_rdata            = rdata_r;
	assign o_match_event      = match_r;
	assign o_store_full_error = full_r;
	assign o_fill_flag        = fill_flag_r;
	assign o_irq              = irq_r;
endmodule
`default_nettype wire

// [dv/pcq_pos_src.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Position sources: feedback, master and commanded position
// ****************************************************************
module pcq_pos_src (
	input  wire logic                       i_mclk,
	input  wire logic                       i_reset_n,
	input  wire logic                       i_load,
	input  wire logic [1:0]                 i_sel,
	input  wire logic [pcq_pkg::DATA_W-1:0] i_val,
	output logic      [pcq_pkg::DATA_W-1:0] o_feedback_pos,
	output logic      [pcq_pkg::DATA_W-1:0] o_master_pos,
	output logic      [pcq_pkg::DATA_W-1:0] o_command_pos
);
	logic [pcq_pkg::DATA_W-1:0] pos_r [3];

	// Each source holds its value until the program moves it.
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			pos_r <= '{default: '0};
		end else if (i_load && i_sel < 2'h3) begin
			pos_r[i_sel] <= i_val;
		end
	end
	assign o_feedback_pos = pos_r[0];
	assign o_master_pos   = pos_r[1];
	assign o_command_pos  = pos_r[2];
endmodule
`default_nettype wire

// [dv/pcq_top_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module pcq_top_chk (
	input  wire logic                       i_mclk,
	input  wire logic                       i_reset_n,
	input  wire logic [pcq_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [pcq_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	input  wire logic [pcq_pkg::DATA_W-1:0] o_rdata,
	input  wire logic                       o_match_event,
	input  wire logic                       o_store_full_error,
	input  wire logic                       o_fill_flag
);
	logic gate_r;
	logic gate_nxt;

	always_comb begin
		gate_nxt = gate_r;
		if (i_wr && i_addr == pcq_pkg::REG_CTRL) begin
			gate_nxt = i_wdata[pcq_pkg::CTRL_GATE_BIT];
		end
	end
	always_ff @(posedge i_mclk) begin
		gate_r <= i_reset_n ? gate_nxt : 1'b0;
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	sequence s_wr(a);
		i_wr && i_addr == a;
	endsequence
	sequence s_remove;
		s_wr(pcq_pkg::REG_CMD) ##0 i_wdata[pcq_pkg::CMD_REMOVE_BIT];
	endsequence

	property p_remove;
		s_remove |=> !o_match_event;
	endproperty
	a_remove: assert property (p_remove) else $error("match stayed after remove");
	property p_gate;
		$rose(o_match_event) |-> $past(gate_r);
	endproperty
	a_gate: assert property (p_gate) else $error("match while gate off");
	property p_refuse;
		o_store_full_error ##0 s_wr(pcq_pkg::REG_PUSH)
			##0 !$past(i_wr && (i_addr == pcq_pkg::REG_CMD
			|| i_addr == pcq_pkg::REG_CAPACITY))
			|=> o_store_full_error;
	endproperty
	a_refuse: assert property (p_refuse) else $error("push taken while full");
	property p_full_rise;
		$rose(o_store_full_error) |-> $past(i_wr && (i_addr == pcq_pkg::REG_PUSH
			|| i_addr == pcq_pkg::REG_CAPACITY), 2);
	endproperty
	a_full_rise: assert property (p_full_rise) else $error("full rose without cause");
	property p_fill_rise;
		$rose(o_fill_flag) |-> $past(i_wr && (i_addr == pcq_pkg::REG_PUSH
			|| i_addr == pcq_pkg::REG_FILL), 2);
	endproperty
	a_fill_rise: assert property (p_fill_rise) else $error("fill rose without cause");
	property p_fill_fall;
		$fell(o_fill_flag) |-> $past(i_wr && (i_addr == pcq_pkg::REG_CMD
			|| i_addr == pcq_pkg::REG_FILL), 2);
	endproperty
	a_fill_fall: assert property (p_fill_fall) else $error("fill fell without cause");
	property p_rd_idle;
		!$past(i_rd) |-> o_rdata == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unmapped;
		$past(i_rd && i_addr > pcq_pkg::REG_COUNT) |-> o_rdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind pcq_top pcq_top_chk u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_match_event(o_match_event), .o_store_full_error(o_store_full_error),
	.o_fill_flag(o_fill_flag));
`default_nettype wire

// [dv/tb_position_compare_queue.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_position_compare_queue;
	logic        i_mclk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        ld = 1'b0;
	logic [1:0]  sel = 2'h0;
	logic [3:0]  i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic [31:0] pv = 32'h0000_0000;
	logic [31:0] rv, rdata, fb, ms, cm;
	logic        m, fe, fl, irq;
	int          fails = 0;
	int          n_checks = 0;

	pcq_top u_pcq_top (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
		.i_feedback_pos(fb), .i_master_pos(ms), .i_command_pos(cm), .o_match_event(m),
		.o_store_full_error(fe), .o_fill_flag(fl), .o_irq(irq));
	pcq_pos_src u_pcq_pos_src (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_load(ld),
		.i_sel(sel), .i_val(pv), .o_feedback_pos(fb), .o_master_pos(ms), .o_command_pos(cm));

	always #4 i_mclk = ~i_mclk;

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task automatic pos(input logic [1:0] s, input logic [31:0] v);
		@(posedge i_mclk);
		ld <= 1'b1;
		sel <= s;
		pv <= v;
		@(posedge i_mclk);
		ld <= 1'b0;
	endtask
	task automatic settle;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask

	task automatic t_order;
		wr(pcq_pkg::REG_OFFSET, 32'h0000_0010);
		wr(pcq_pkg::REG_PUSH, 32'h0000_0100);
		wr(pcq_pkg::REG_OFFSET, 32'h0000_0020);
		wr(pcq_pkg::REG_PUSH, 32'h0000_0200);
		wr(pcq_pkg::REG_PUSH, 32'h0000_0300);
		rd(pcq_pkg::REG_HEAD);
		`CHK("head", 32'h0000_0100, rv)
		rd(pcq_pkg::REG_TARGET);
		`CHK("target", 32'h0000_0110, rv)
		wr(pcq_pkg::REG_CMD, 32'h0000_0001);
		rd(pcq_pkg::REG_HEAD);
		`CHK("head", 32'h0000_0200, rv)
		rd(pcq_pkg::REG_TARGET);
		`CHK("target", 32'h0000_0220, rv)
	endtask

	task automatic t_match;
		for (int s = 0; s < 3; s++) begin
			wr(pcq_pkg::REG_CMD, 32'h0000_0002);
			wr(pcq_pkg::REG_OFFSET, 32'h0000_000A);
			for (int k = 0; k < 3; k++) pos(2'(k), 32'h0000_0000);
			pos(2'(s), 32'h0000_000F);
			wr(pcq_pkg::REG_CTRL, 32'(s) << 1);
			wr(pcq_pkg::REG_PUSH, 32'h0000_0005);
			settle;
			`CHK("match", 1'b0, m)
			wr(pcq_pkg::REG_CTRL, (32'(s) << 1) | 32'h0000_0001);
			settle;
			`CHK("match", 1'b1, m)
			wr(pcq_pkg::REG_CMD, 32'h0000_0001);
			settle;
			`CHK("match", 1'b0, m)
		end
	endtask

	task automatic t_irq;
		rd(pcq_pkg::REG_IRQ_STAT);
		`CHK("irq status", 1'b1, rv[pcq_pkg::IRQ_MATCH_BIT])
		`CHK("irq", 1'b0, irq)
		wr(pcq_pkg::REG_IRQ_MASK, 32'h0000_0001);
		settle;
		`CHK("irq", 1'b1, irq)
		wr(pcq_pkg::REG_IRQ_STAT, 32'h0000_0001);
		settle;
		`CHK("irq", 1'b0, irq)
		wr(4'hF, 32'hFFFF_FFFF);
		rd(4'hF);
		`CHK("unmapped", 32'h0000_0000, rv)
	endtask

	task automatic t_full;
		wr(pcq_pkg::REG_CTRL, 32'h0000_0000);
		wr(pcq_pkg::REG_CMD, 32'h0000_0002);
		wr(pcq_pkg::REG_CAPACITY, 32'h0000_0004);
		wr(pcq_pkg::REG_FILL, 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			wr(pcq_pkg::REG_PUSH, 32'(i + 1));
			settle;
			`CHK("fill", i >= 2, fl)
			`CHK("full", i == 3, fe)
		end
		wr(pcq_pkg::REG_PUSH, 32'h0000_0099);
		rd(pcq_pkg::REG_COUNT);
		`CHK("count", 32'h0000_0004, rv)
		rd(pcq_pkg::REG_HEAD);
		`CHK("head", 32'h0000_0001, rv)
		rd(pcq_pkg::REG_STATUS);
		`CHK("status", 32'h0000_0006, rv)
		// A remove and a push back to back: the flag still shows, so the push is refused.
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= pcq_pkg::REG_CMD;
		i_wdata <= 32'h0000_0001;
		@(posedge i_mclk);
		i_addr <= pcq_pkg::REG_PUSH;
		i_wdata <= 32'h0000_0055;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		settle;
		rd(pcq_pkg::REG_COUNT);
		`CHK("count", 32'h0000_0003, rv)
		`CHK("full", 1'b0, fe)
		`CHK("fill", 1'b1, fl)
		wr(pcq_pkg::REG_CMD, 32'h0000_0001);
		settle;
		`CHK("fill", 1'b0, fl)
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		t_order;
		t_match;
		t_irq;
		t_full;
		end_of_test;
	end

	// A hang is cut short well after the fewer than two hundred cycles the tests need.
	initial begin
		repeat (20000) @(posedge i_mclk);
		fails++;
		end_of_test;
	end
endmodule
`default_nettype wire
